// [rtl/scr_config_bank.sv]
// Configuration register bank of the frequency synthesizer: buffer, active bank, update timer
`include "scr_defs.svh"
module scr_config_bank (
   // Clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic MASTER_RESET,
   // Byte port
   input wire logic [5:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // External update strobe
   input wire logic UPDATE_STROBE,
   // Active configuration
   output logic [13:0] PHASE_ONE,
   output logic [13:0] PHASE_TWO,
   output logic [47:0] FREQ_ONE,
   output logic [47:0] FREQ_TWO,
   output logic [47:0] FREQ_STEP,
   output logic [19:0] SWEEP_STEP_INTERVAL,
   output logic [11:0] INPHASE_SCALE,
   output logic [11:0] QUAD_SCALE,
   output logic [7:0] KEYING_RAMP_RATE,
   output logic [11:0] AUXILIARY_LEVEL_WORD,
   output logic [7:0] OPERATING_MODE,
   output logic SHAPED_KEYING_ON,
   // Stage power and clock multiplier
   output logic COMPARATOR_POWER_OFF,
   output logic SECOND_CONVERTER_POWER_OFF,
   output logic CONVERTER_POWER_OFF,
   output logic LOGIC_POWER_OFF,
   output logic PLL_BYPASS,
   output logic [4:0] MULT_FACTOR
);
   // ------------------------------------------------------------
   // Address tables
   // ------------------------------------------------------------
   // Default byte for each address
   function automatic scr_pkg::scr_byte_t dflt(input scr_pkg::scr_addr_t a);
      unique case (a)
         `SCR_A_INTERVAL_LO: dflt = `SCR_RST_INTERVAL_LO;
         `SCR_A_POWER: dflt = `SCR_RST_POWER;
         `SCR_A_MULT: dflt = `SCR_RST_MULT;
         `SCR_A_MODE: dflt = `SCR_RST_MODE;
         `SCR_A_PORT: dflt = `SCR_RST_PORT;
         `SCR_A_RAMP: dflt = `SCR_RST_RAMP;
         default: dflt = `SCR_RST_ZERO;
      endcase
   endfunction : dflt

   // Writable bits of each address; ignored bits stay zero
   function automatic scr_pkg::scr_byte_t wmask(input scr_pkg::scr_addr_t a);
      if (a > `SCR_LAST_ADDR) begin
         wmask = `SCR_MASK_NONE;
      end else begin
         unique case (a)
            `SCR_A_PHASE1_HI, `SCR_A_PHASE2_HI: wmask = `SCR_MASK_PHASE_HI;
            `SCR_A_SWEEP_HI, `SCR_A_ISCALE_HI: wmask = `SCR_MASK_NIBBLE;
            `SCR_A_QSCALE_HI, `SCR_A_AUX_HI: wmask = `SCR_MASK_NIBBLE;
            `SCR_A_POWER: wmask = `SCR_MASK_POWER;
            `SCR_A_MULT: wmask = `SCR_MASK_MULT;
            `SCR_A_PORT: wmask = `SCR_MASK_PORT;
            default: wmask = `SCR_MASK_ALL;
         endcase
      end
   endfunction : wmask

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   scr_pkg::scr_byte_t buf_reg [0:`SCR_NUM_BYTES-1]; // Port-side buffer
   scr_pkg::scr_byte_t act_reg [0:`SCR_NUM_BYTES-1]; // Active bank
   logic [31:0] cnt_reg; // Internal update countdown
   logic strobe_prev_reg; // Strobe level last cycle
   logic [7:0] rdata_reg; // Read answer
   logic update_now; // Buffer-to-bank transfer this edge
   logic [31:0] interval; // Active update interval
   logic internal_mode; // Timer drives updates

   assign interval = {act_reg[`SCR_A_INTERVAL], act_reg[`SCR_A_INTERVAL+6'h01],
                      act_reg[`SCR_A_INTERVAL+6'h02], act_reg[`SCR_A_INTERVAL+6'h03]};
   assign internal_mode = act_reg[`SCR_A_MODE][`SCR_BIT_INT_UPDATE];

   // ------------------------------------------------------------
   // Update source
   // ------------------------------------------------------------
   // Timer expiry in internal mode, strobe rise otherwise
   always_comb begin
      if (internal_mode) begin
         update_now = (cnt_reg == 32'h0000_0000);
      end else begin
         update_now = UPDATE_STROBE & ~strobe_prev_reg;
      end
   end

   // Strobe edge detector
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         strobe_prev_reg <= 1'b0;
      end else begin
         strobe_prev_reg <= UPDATE_STROBE;
      end
   end

   // Countdown reloads on each transfer; period is interval plus one
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_reg <= {24'h00_0000, `SCR_RST_INTERVAL_LO};
      end else if (MASTER_RESET) begin
         cnt_reg <= {24'h00_0000, `SCR_RST_INTERVAL_LO};
      end else if (update_now) begin
         cnt_reg <= interval;
      end else begin
         cnt_reg <= cnt_reg - 32'h0000_0001;
      end
   end

   // ------------------------------------------------------------
   // Buffer and active bank
   // ------------------------------------------------------------
   // Port writes land in the buffer, masked
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int i = 0; i < `SCR_NUM_BYTES; i++) begin
            buf_reg[i] <= dflt(6'(i));
         end
      end else if (MASTER_RESET) begin
         for (int i = 0; i < `SCR_NUM_BYTES; i++) begin
            buf_reg[i] <= dflt(6'(i));
         end
      end else if (WR && ADDR <= `SCR_LAST_ADDR) begin
         buf_reg[ADDR] <= WDATA & wmask(ADDR);
      end
   end

   // Active bank copies the whole buffer on a transfer
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int i = 0; i < `SCR_NUM_BYTES; i++) begin
            act_reg[i] <= dflt(6'(i));
         end
      end else if (MASTER_RESET) begin
         for (int i = 0; i < `SCR_NUM_BYTES; i++) begin
            act_reg[i] <= dflt(6'(i));
         end
      end else if (update_now) begin
         for (int i = 0; i < `SCR_NUM_BYTES; i++) begin
            act_reg[i] <= buf_reg[i];
         end
      end
   end

   // Readback of the active bank; unmapped reads zero
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_reg <= 8'h00;
      end else if (RD) begin
         rdata_reg <= (ADDR <= `SCR_LAST_ADDR) ? act_reg[ADDR] : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Outputs, wired straight from bank flops; RDATA from the read answer flop
   // ------------------------------------------------------------
   assign RDATA = rdata_reg;
   assign PHASE_ONE = {act_reg[`SCR_A_PHASE1_HI][`SCR_PHASE_HI_MSB:0],
                       act_reg[`SCR_A_PHASE1_LO]};
   assign PHASE_TWO = {act_reg[`SCR_A_PHASE2_HI][`SCR_PHASE_HI_MSB:0],
                       act_reg[`SCR_A_PHASE2_LO]};
   assign FREQ_ONE = {act_reg[`SCR_A_FREQ1], act_reg[`SCR_A_FREQ1+6'h01],
                      act_reg[`SCR_A_FREQ1+6'h02], act_reg[`SCR_A_FREQ1+6'h03],
                      act_reg[`SCR_A_FREQ1+6'h04], act_reg[`SCR_A_FREQ1+6'h05]};
   assign FREQ_TWO = {act_reg[`SCR_A_FREQ2], act_reg[`SCR_A_FREQ2+6'h01],
                      act_reg[`SCR_A_FREQ2+6'h02], act_reg[`SCR_A_FREQ2+6'h03],
                      act_reg[`SCR_A_FREQ2+6'h04], act_reg[`SCR_A_FREQ2+6'h05]};
   assign FREQ_STEP = {act_reg[`SCR_A_STEP], act_reg[`SCR_A_STEP+6'h01],
                       act_reg[`SCR_A_STEP+6'h02], act_reg[`SCR_A_STEP+6'h03],
                       act_reg[`SCR_A_STEP+6'h04], act_reg[`SCR_A_STEP+6'h05]};
   assign SWEEP_STEP_INTERVAL = {act_reg[`SCR_A_SWEEP][`SCR_NIB_MSB:0],
                                 act_reg[`SCR_A_SWEEP+6'h01], act_reg[`SCR_A_SWEEP+6'h02]};
   assign INPHASE_SCALE = {act_reg[`SCR_A_ISCALE_HI][`SCR_NIB_MSB:0], act_reg[`SCR_A_ISCALE_LO]};
   assign QUAD_SCALE = {act_reg[`SCR_A_QSCALE_HI][`SCR_NIB_MSB:0], act_reg[`SCR_A_QSCALE_LO]};
   assign KEYING_RAMP_RATE = act_reg[`SCR_A_RAMP];
   assign AUXILIARY_LEVEL_WORD = {act_reg[`SCR_A_AUX_HI][`SCR_NIB_MSB:0], act_reg[`SCR_A_AUX_LO]};
   assign OPERATING_MODE = act_reg[`SCR_A_MODE];
   assign SHAPED_KEYING_ON = act_reg[`SCR_A_PORT][`SCR_BIT_KEYING_ON];
   assign COMPARATOR_POWER_OFF = act_reg[`SCR_A_POWER][`SCR_BIT_COMPARATOR_POWER_OFF];
   assign SECOND_CONVERTER_POWER_OFF = act_reg[`SCR_A_POWER][`SCR_BIT_SECOND_PD];
   assign CONVERTER_POWER_OFF = act_reg[`SCR_A_POWER][`SCR_BIT_CONV_PD];
   assign LOGIC_POWER_OFF = act_reg[`SCR_A_POWER][`SCR_BIT_LOGIC_PD];
   assign PLL_BYPASS = act_reg[`SCR_A_MULT][`SCR_BIT_PLL_BYPASS];
   assign MULT_FACTOR = act_reg[`SCR_A_MULT][`SCR_MULT_MSB:0];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_phase_two_top;
      @(posedge CLK) disable iff (!ARST_N)
      WR && !MASTER_RESET && ADDR == `SCR_A_PHASE2_HI |=> buf_reg[`SCR_A_PHASE2_HI][7:6] == 2'b00;
   endproperty
   a_phase_two_top: assert property (p_phase_two_top) else $error("phase two top bits kept");

   property p_phase_one_reset;
      @(posedge CLK) disable iff (!ARST_N)
      MASTER_RESET |=> PHASE_ONE == 14'h0000;
   endproperty
   a_phase_one_reset: assert property (p_phase_one_reset) else $error("phase one not cleared");

   property p_freq_two_buffer;
      @(posedge CLK) disable iff (!ARST_N)
      WR && !MASTER_RESET && ADDR == `SCR_A_FREQ2 |=> buf_reg[`SCR_A_FREQ2] == $past(WDATA);
   endproperty
   a_freq_two_buffer: assert property (p_freq_two_buffer) else $error("frequency byte lost");

   property p_step_transfer;
      @(posedge CLK) disable iff (!ARST_N)
      update_now && !MASTER_RESET |=> FREQ_STEP[47:40] == $past(buf_reg[`SCR_A_STEP]);
   endproperty
   a_step_transfer: assert property (p_step_transfer) else $error("step word order wrong");

   property p_iscale_transfer;
      @(posedge CLK) disable iff (!ARST_N)
      update_now && !MASTER_RESET |=> INPHASE_SCALE[7:0] == $past(buf_reg[`SCR_A_ISCALE_LO]);
   endproperty
   a_iscale_transfer: assert property (p_iscale_transfer) else $error("in-phase scale wrong");

   property p_qscale_top;
      @(posedge CLK) disable iff (!ARST_N)
      buf_reg[`SCR_A_QSCALE_HI][7:4] == 4'h0;
   endproperty
   a_qscale_top: assert property (p_qscale_top) else $error("quadrature top bits kept");

   property p_ramp_default;
      @(posedge CLK) disable iff (!ARST_N)
      MASTER_RESET |=> KEYING_RAMP_RATE == `SCR_RST_RAMP && LOGIC_POWER_OFF == 1'b0;
   endproperty
   a_ramp_default: assert property (p_ramp_default) else $error("ramp default wrong");

   property p_aux_top;
      @(posedge CLK) disable iff (!ARST_N)
      WR && !MASTER_RESET && ADDR == `SCR_A_AUX_HI |=> buf_reg[`SCR_A_AUX_HI][7:4] == 4'h0;
   endproperty
   a_aux_top: assert property (p_aux_top) else $error("auxiliary top bits kept");

   property p_hold_without_update;
      @(posedge CLK) disable iff (!ARST_N)
      !update_now && !MASTER_RESET |=> $stable(FREQ_ONE) && $stable(PHASE_TWO);
   endproperty
   a_hold_without_update: assert property (p_hold_without_update) else $error("bank moved");

   property p_master_defaults;
      @(posedge CLK) disable iff (!ARST_N)
      MASTER_RESET |=> COMPARATOR_POWER_OFF && MULT_FACTOR == `SCR_RST_MULT_FACTOR && internal_mode;
   endproperty
   a_master_defaults: assert property (p_master_defaults) else $error("defaults not loaded");

   property p_timer_period;
      @(posedge CLK) disable iff (!ARST_N || MASTER_RESET)
      internal_mode && cnt_reg == '0 |=> KEYING_RAMP_RATE == $past(buf_reg[`SCR_A_RAMP]);
   endproperty
   a_timer_period: assert property (p_timer_period) else $error("timer did not update");

   property p_unmapped_read;
      @(posedge CLK) disable iff (!ARST_N)
      RD && ADDR > `SCR_LAST_ADDR |=> RDATA == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");
endmodule : scr_config_bank

// [rtl/scr_defs.svh]
// Byte addresses, reset values, field positions and timing of the synthesizer register bank
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
// ------------------------------------------------------------
// Byte addresses
// ------------------------------------------------------------
`define SCR_NUM_BYTES 40
`define SCR_LAST_ADDR 6'h27
`define SCR_A_PHASE1_HI 6'h00
`define SCR_A_PHASE1_LO 6'h01
`define SCR_A_PHASE2_HI 6'h02
`define SCR_A_PHASE2_LO 6'h03
`define SCR_A_FREQ1 6'h04
`define SCR_A_FREQ2 6'h0A
`define SCR_A_STEP 6'h10
`define SCR_A_INTERVAL 6'h16
`define SCR_A_INTERVAL_LO 6'h19
`define SCR_A_SWEEP_HI 6'h1A
`define SCR_A_SWEEP 6'h1A
`define SCR_A_POWER 6'h1D
`define SCR_A_MULT 6'h1E
`define SCR_A_MODE 6'h1F
`define SCR_A_PORT 6'h20
`define SCR_A_ISCALE_HI 6'h21
`define SCR_A_ISCALE_LO 6'h22
`define SCR_A_QSCALE_HI 6'h23
`define SCR_A_QSCALE_LO 6'h24
`define SCR_A_RAMP 6'h25
`define SCR_A_AUX_HI 6'h26
`define SCR_A_AUX_LO 6'h27
// ------------------------------------------------------------
// Reset values and writable-bit masks
// ------------------------------------------------------------
`define SCR_RST_ZERO 8'h00
`define SCR_RST_INTERVAL_LO 8'h40
`define SCR_RST_POWER 8'h10
`define SCR_RST_MULT 8'h64
`define SCR_RST_MODE 8'h01
`define SCR_RST_PORT 8'h20
`define SCR_RST_RAMP 8'h80
`define SCR_MASK_ALL 8'hFF
`define SCR_MASK_NONE 8'h00
`define SCR_MASK_PHASE_HI 8'h3F
`define SCR_MASK_NIBBLE 8'h0F
`define SCR_MASK_POWER 8'h17
`define SCR_MASK_MULT 8'h7F
`define SCR_MASK_PORT 8'h73
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SCR_BIT_COMPARATOR_POWER_OFF 4
`define SCR_BIT_SECOND_PD 2
`define SCR_BIT_CONV_PD 1
`define SCR_BIT_LOGIC_PD 0
`define SCR_BIT_PLL_BYPASS 5
`define SCR_MULT_MSB 4
`define SCR_BIT_INT_UPDATE 0
`define SCR_BIT_KEYING_ON 5
`define SCR_NIB_MSB 3
`define SCR_PHASE_HI_MSB 5
`define SCR_RST_MULT_FACTOR 5'h04
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SCR_MASTER_RESET_CYCLES 10
`endif

// [rtl/scr_pkg.sv]
// Types shared by the synthesizer register bank
package scr_pkg;
   // Register byte and byte address
   typedef logic [7:0] scr_byte_t;
   typedef logic [5:0] scr_addr_t;
endpackage : scr_pkg

// [test/scr_host_model.sv]
// Host model driving the byte port, update strobe and master reset
module scr_host_model (
   // Clock
   input wire logic clk,
   // Byte port
   output logic [5:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [7:0] rdata,
   // Update and reset
   output logic strobe,
   output logic mreset
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle levels at time zero
   initial begin
      addr = 6'h3F;
      wdata = 8'hA5;
      wr = 1'b0;
      rd = 1'b0;
      strobe = 1'b0;
      mreset = 1'b0;
   end
   // One write cycle; released bus shows inverted values
   task automatic put(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask : put
   // One read cycle; byte taken after the answer edge
   task automatic get(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask : get
   task automatic put_aux(input logic signed [11:0] v);
      put(6'h26, {4'h0, v[11:8]});
      put(6'h27, v[7:0]);
   endtask : put_aux
   // Single rising edge of the update strobe
   task automatic pulse();
      @(posedge clk);
      strobe <= 1'b1;
      @(posedge clk);
      strobe <= 1'b0;
      #1;
   endtask : pulse
   task automatic hold_reset();
      @(posedge clk);
      mreset <= 1'b1;
      repeat (10) @(posedge clk);
      mreset <= 1'b0;
   endtask : hold_reset
endmodule : scr_host_model

// [test/synth_config_register_map_tb.sv]
// Self-checking bench of the register bank against a byte-array model
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin num_errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module synth_config_register_map_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals and model state
   // ------------------------------------------------------------
   logic CLK, ARST_N, MR, WR, RD, STB;
   logic [5:0] ADDR;
   logic [7:0] WDATA, RDATA, v;
   logic [13:0] PH1, PH2;
   logic [47:0] F1, F2, FS;
   logic [19:0] SW;
   logic [11:0] IS, QS, AUX;
   logic [7:0] KR, OM;
   logic [4:0] MF;
   logic OSK, CPD, SPD, VPD, LPD, BYP;
   logic [7:0] buf_q [40];
   logic [7:0] bank_q [40];
   logic [31:0] seed = 32'hFF358AD9;
   int num_errors = 0;
   int total_checks = 0;
   int n;
   // ------------------------------------------------------------
   // Design, host and clock
   // ------------------------------------------------------------
   scr_config_bank i_scr_config_bank (.CLK(CLK), .ARST_N(ARST_N), .MASTER_RESET(MR),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .UPDATE_STROBE(STB),
      .PHASE_ONE(PH1), .PHASE_TWO(PH2), .FREQ_ONE(F1), .FREQ_TWO(F2), .FREQ_STEP(FS),
      .SWEEP_STEP_INTERVAL(SW), .INPHASE_SCALE(IS), .QUAD_SCALE(QS), .KEYING_RAMP_RATE(KR),
      .AUXILIARY_LEVEL_WORD(AUX), .OPERATING_MODE(OM), .SHAPED_KEYING_ON(OSK),
      .COMPARATOR_POWER_OFF(CPD), .SECOND_CONVERTER_POWER_OFF(SPD), .CONVERTER_POWER_OFF(VPD),
      .LOGIC_POWER_OFF(LPD), .PLL_BYPASS(BYP), .MULT_FACTOR(MF));
   scr_host_model i_scr_host_model (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR),
      .rd(RD), .rdata(RDATA), .strobe(STB), .mreset(MR));
   // Free-running system clock
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   // ------------------------------------------------------------
   // Model helpers
   // ------------------------------------------------------------
   // Xorshift source
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   function automatic logic [7:0] mask(int a);
      case (a)
         8'h00, 8'h02: return 8'h3F;
         8'h1A, 8'h21, 8'h23, 8'h26: return 8'h0F;
         8'h1D: return 8'h17;
         8'h1E: return 8'h7F;
         8'h20: return 8'h73;
         default: return 8'hFF;
      endcase
   endfunction : mask
   // Reset values per byte
   function automatic logic [7:0] dflt(int a);
      case (a)
         8'h19: return 8'h40;
         8'h1D: return 8'h10;
         8'h1E: return 8'h64;
         8'h1F: return 8'h01;
         8'h20: return 8'h20;
         8'h25: return 8'h80;
         default: return 8'h00;
      endcase
   endfunction : dflt
   // Six model bytes, lowest address as most significant
   function automatic logic [47:0] w48(int a);
      return {bank_q[a], bank_q[a+1], bank_q[a+2], bank_q[a+3], bank_q[a+4], bank_q[a+5]};
   endfunction : w48
   // Model back to defaults
   task automatic model_reset();
      for (int a = 0; a < 40; a++) begin
         buf_q[a] = dflt(a);
         bank_q[a] = dflt(a);
      end
   endtask : model_reset
   // Write through host and into model buffer
   task automatic mwrite(int a, logic [7:0] d);
      i_scr_host_model.put(a[5:0], d);
      buf_q[a] = d & mask(a);
   endtask : mwrite
   // Read every byte plus one unmapped, then compare outputs
   task automatic check_all();
      for (int a = 0; a <= 40; a++) begin
         i_scr_host_model.get(a[5:0], v);
         `CHK("rdata", (a < 40) ? bank_q[a] : 8'h00, v)
      end
      `CHK("phase one", {bank_q[0][5:0], bank_q[1]}, PH1)
      `CHK("phase two", {bank_q[2][5:0], bank_q[3]}, PH2)
      `CHK("freq one", w48(4), F1)
      `CHK("freq two", w48(10), F2)
      `CHK("step", w48(16), FS)
      `CHK("sweep", {bank_q[26][3:0], bank_q[27], bank_q[28]}, SW)
      `CHK("mode", bank_q[31], OM)
      `CHK("keying on", bank_q[32][5], OSK)
      `CHK("i scale", {bank_q[33][3:0], bank_q[34]}, IS)
      `CHK("q scale", {bank_q[35][3:0], bank_q[36]}, QS)
      `CHK("ramp", bank_q[37], KR)
      `CHK("aux", {bank_q[38][3:0], bank_q[39]}, AUX)
      `CHK("comp off", bank_q[29][4], CPD)
      `CHK("logic off", bank_q[29][0], LPD)
      `CHK("second off", bank_q[29][2], SPD)
      `CHK("conv off", bank_q[29][1], VPD)
      `CHK("mult", bank_q[30][4:0], MF)
      `CHK("pll bypass", bank_q[30][5], BYP)
   endtask : check_all
   // Count summary and verdict
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   // Watchdog against a hang
   initial begin
      #(50 * 6000);
      num_errors++;
      report_and_stop();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      ARST_N = 1'b0;
      model_reset();
      repeat (6) @(posedge CLK);
      ARST_N <= 1'b1;
      check_all();
      // Select external update; timer carries it over
      mwrite(8'h1F, 8'h00);
      repeat (70) @(posedge CLK);
      bank_q = buf_q;
      // Random bytes into the buffer, one unmapped write
      for (int a = 0; a < 40; a++) begin
         if (a != 8'h1F) mwrite(a, rnd());
      end
      i_scr_host_model.put_aux(-12'sd5);
      buf_q[38] = 8'h0F;
      buf_q[39] = 8'hFB;
      i_scr_host_model.put(6'h2A, 8'hFF);
      check_all();
      i_scr_host_model.pulse();
      bank_q = buf_q;
      check_all();
      `CHK("aux neg", 12'hFFB, AUX)
      // Buffered byte lost by master reset
      mwrite(8'h25, 8'h55);
      i_scr_host_model.hold_reset();
      model_reset();
      check_all();
      // Internal timer applies the next write
      mwrite(8'h25, 8'h55);
      n = 0;
      while (KR !== 8'h55 && n < 80) begin
         @(posedge CLK);
         #1;
         n++;
      end
      `CHK("timer span", 1'b1, n <= 65)
      report_and_stop();
   end
endmodule : synth_config_register_map_tb
